/* hw/spisc_controller.sv */
// Serial peripheral controller with transmit and receive queues
//
// Contract
// - Master bit rate stays at or below 65 Mbps and slave at 45 Mbps.
// - The link is chip select (low active), clock, master out, master in.
// - Each bit is launched on one clock edge and sampled on the other.
// - Receive and transmit queues are separate and independent.
// - Packet length is bit_len_i plus one, from 1 to 32 bits.
// - Packing several packets per word works only at lengths 8 and 16.
// - Chip select is either software driven or asserted per packet.
// - In compare mode data is queued only after the pattern is seen.
// - Transmit and receive happen together in every transfer.
// - Master is the primary role; the slave role is best effort.
// - Clock polarity is programmable.
// - At default polarity data launches on falling, samples on rising.

module spisc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [WIDTH-1:0] in_data_i, // Write data
	input wire logic in_valid_i, // Write request
	output logic in_ready_o, // Room for a word
	output logic [WIDTH-1:0] out_data_o, // Head word
	output logic out_valid_o, // Head word present
	input wire logic out_ready_i // Head word taken
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	logic valid_q;
	logic wr_en;
	logic rd_en;

	// Flags kept as flops in their output sense, so the ports are flops
	assign wr_en = in_valid_i && ready_q;
	assign rd_en = out_ready_i && valid_q;
	assign in_ready_o = ready_q;
	assign out_valid_o = valid_q;
	assign out_data_o = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (wr_en && !rd_en) begin
			cnt_d = cnt_q + 1'b1;
		end else if (rd_en && !wr_en) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (wr_en) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
			valid_q <= 1'b0;
		end else begin
			if (wr_en) begin
				wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
			end
			if (rd_en) begin
				rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != CNT_FULL);
			valid_q <= (cnt_d != '0);
		end
	end
endmodule

module spisc_controller
	import spisc_pkg::*;
(
	input wire logic ref_clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic master_en_i, // 1 master, 0 slave
	input wire logic [4:0] bit_len_i, // Packet bits minus one
	input wire logic packed_i, // Pack 8/16-bit packets per word
	input wire logic cs_auto_i, // Hardware chip select per packet
	input wire logic cs_sw_assert_i, // Software chip select level
	input wire logic cs_sel_i, // Chip select 0 or 1
	input wire logic clk_pol_i, // Idle clock level
	input wire logic [7:0] half_period_i, // Clock half period, cycles
	input wire logic cmp_en_i, // Receive compare mode
	input wire logic [31:0] cmp_pattern_i, // Pattern to wait for
	output logic busy_o, // Transfer in progress
	output logic cmp_matched_o, // Pattern has been seen
	input wire logic [31:0] tx_data_i, // Transmit word
	input wire logic tx_valid_i, // Transmit word valid
	output logic tx_ready_o, // Transmit queue has room
	output logic [31:0] rx_data_o, // Received word
	output logic rx_valid_o, // Received word valid
	input wire logic rx_ready_i, // Received word taken
	input wire logic [1:0] link_chip_select_i, // Chip select pins in
	output logic [1:0] link_chip_select_o, // Chip select pins out
	output logic [1:0] link_chip_select_oe_n_o, // Low while driving
	input wire logic link_serial_clock_i, // Clock pin in
	output logic link_serial_clock_o, // Clock pin out
	output logic link_serial_clock_oe_n_o, // Low while driving
	input wire logic link_master_out_i, // Master out pin in
	output logic link_master_out_o, // Master out pin out
	output logic link_master_out_oe_n_o, // Low while driving
	input wire logic link_master_in_i, // Master in pin in
	output logic link_master_in_o, // Master in pin out
	output logic link_master_in_oe_n_o // Low while driving
);
	function automatic logic [1:0] last_pkt(input logic pk,
		input logic [4:0] len);
		last_pkt = 2'h0;
		if (pk && len == PACK8_LEN) begin
			last_pkt = PACK8_LAST;
		end else if (pk && len == PACK16_LEN) begin
			last_pkt = PACK16_LAST;
		end
	endfunction

	function automatic logic [4:0] pkt_base(input logic [1:0] idx,
		input logic [4:0] len);
		logic [6:0] p;
		p = {5'h00, idx} * ({2'h0, len} + 7'h01);
		pkt_base = p[4:0];
	endfunction

	spisc_state_type state_q;
	logic [7:0] hcnt_q;
	logic [7:0] half;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic sck_prev_q;
	logic csn_prev_q;
	logic [31:0] tx_word_q;
	logic have_word_q;
	logic [1:0] pkt_idx_q;
	logic [1:0] pkt_idx_d;
	logic [4:0] bit_cnt_q;
	logic [4:0] bit_cnt_d;
	logic [31:0] rx_sh_q;
	logic [31:0] rx_word_q;
	logic [1:0] rx_idx_q;
	logic matched_q;
	logic push_v_q;
	logic [31:0] push_d_q;
	logic out_q;
	logic [1:0] npk_last;
	logic last_bit;
	logic word_end;
	logic [4:0] pos;
	logic [31:0] mask;
	logic [31:0] pv;
	logic in_bit;
	logic s_cs_act;
	logic s_smp;
	logic s_lch;
	logic s_frame;
	logic m_edge;
	logic smp;
	logic lch;
	logic start;
	logic pop;
	logic tx_head_v;
	logic [31:0] tx_head;
	logic rx_room;
	logic cs_active;

	spisc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_data_i(tx_data_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_ready_o),
		.out_data_o(tx_head),
		.out_valid_o(tx_head_v),
		.out_ready_i(pop)
	);

	spisc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.in_data_i(push_d_q),
		.in_valid_i(push_v_q),
		.in_ready_o(rx_room),
		.out_data_o(rx_data_o),
		.out_valid_o(rx_valid_o),
		.out_ready_i(rx_ready_i)
	);

	// Pins pass two flops; edge logic only reads the second stage
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			meta_q <= SYNC_RST;
			sync_q <= SYNC_RST;
			sck_prev_q <= 1'b1;
			csn_prev_q <= 1'b1;
		end else begin
			meta_q <= {link_master_in_i, link_master_out_i,
				link_chip_select_i[0], link_serial_clock_i};
			sync_q <= meta_q;
			sck_prev_q <= sync_q[SYNC_SCK];
			csn_prev_q <= sync_q[SYNC_CSN];
		end
	end

	// Slave listens on chip select 0; sampling at 100 MHz caps its rate
	assign s_cs_act = !master_en_i && !sync_q[SYNC_CSN];
	assign s_frame = s_cs_act && csn_prev_q;
	assign s_smp = s_cs_act && (sync_q[SYNC_SCK] ^ clk_pol_i) &&
		!(sck_prev_q ^ clk_pol_i);
	assign s_lch = s_cs_act && !(sync_q[SYNC_SCK] ^ clk_pol_i) &&
		(sck_prev_q ^ clk_pol_i);

	// Divider never runs faster than the rate limit or the input sync
	assign half = (half_period_i < HALF_MIN_CYC) ? HALF_MIN_CYC :
		half_period_i;
	// Master in is latched at the end of the high half: the sync delay
	// then still points inside the half where the bit is stable
	assign m_edge = master_en_i && state_q == ST_HIGH && hcnt_q == half;
	assign smp = m_edge || s_smp;
	assign lch = m_edge || s_lch;
	assign in_bit = master_en_i ? sync_q[SYNC_MISO] :
		sync_q[SYNC_MOSI];

	assign npk_last = last_pkt(packed_i, bit_len_i);
	assign last_bit = (bit_cnt_q == bit_len_i);
	assign word_end = smp && last_bit && (pkt_idx_q == npk_last);
	assign mask = 32'hffffffff >> (5'h1f - bit_len_i);
	assign pv = {rx_sh_q[30:0], in_bit} & mask;

	always_comb begin
		bit_cnt_d = bit_cnt_q;
		pkt_idx_d = pkt_idx_q;
		if (smp) begin
			if (last_bit) begin
				bit_cnt_d = 5'h00;
				pkt_idx_d = (pkt_idx_q == npk_last) ? 2'h0 :
					pkt_idx_q + 2'h1;
			end else begin
				bit_cnt_d = bit_cnt_q + 5'h01;
			end
		end
	end

	// Packets go low slot first, each one most significant bit first
	assign pos = pkt_base(pkt_idx_d, bit_len_i) + bit_len_i - bit_cnt_d;

	// Software chip select gates the start so the clock stays idle
	assign start = master_en_i && state_q == ST_IDLE && have_word_q &&
		rx_room && !push_v_q &&
		(cs_auto_i || cs_sw_assert_i);
	assign pop = !have_word_q && tx_head_v &&
		(!master_en_i || state_q == ST_IDLE);
	assign cs_active = cs_auto_i ?
		(state_q == ST_LOW || state_q == ST_HIGH) :
		cs_sw_assert_i;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			hcnt_q <= HCNT_RST;
		end else if (!master_en_i) begin
			state_q <= ST_IDLE;
			hcnt_q <= HCNT_RST;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					hcnt_q <= HCNT_RST;
					if (start) begin
						state_q <= ST_LOW;
					end
				end
				ST_LOW: begin
					hcnt_q <= (hcnt_q == half) ? HCNT_RST : hcnt_q + 8'h01;
					if (hcnt_q == half) begin
						state_q <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					hcnt_q <= (hcnt_q == half) ? HCNT_RST : hcnt_q + 8'h01;
					if (hcnt_q == half) begin
						state_q <= last_bit ? ST_GAP : ST_LOW;
					end
				end
				ST_GAP: begin
					hcnt_q <= (hcnt_q >= half) ? HCNT_RST : hcnt_q + 8'h01;
					if (hcnt_q >= half) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_word_q <= '0;
			have_word_q <= 1'b0;
			pkt_idx_q <= 2'h0;
			bit_cnt_q <= 5'h00;
			rx_sh_q <= '0;
			out_q <= 1'b0;
		end else begin
			if (pop) begin
				tx_word_q <= tx_head;
				have_word_q <= 1'b1;
				pkt_idx_q <= 2'h0;
			end else if (word_end) begin
				tx_word_q <= '0;
				have_word_q <= 1'b0;
				pkt_idx_q <= 2'h0;
			end else begin
				pkt_idx_q <= pkt_idx_d;
			end
			// An aborted frame drops the partial packet
			if ((master_en_i && state_q == ST_IDLE) ||
				(!master_en_i && !s_cs_act)) begin
				bit_cnt_q <= 5'h00;
			end else begin
				bit_cnt_q <= bit_cnt_d;
			end
			if (smp) begin
				rx_sh_q <= {rx_sh_q[30:0], in_bit};
			end
			if (start || s_frame || lch) begin
				out_q <= tx_word_q[pos];
			end
		end
	end

	// Receive side; a slave overrun drops the word, the master waits
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_word_q <= '0;
			rx_idx_q <= 2'h0;
			matched_q <= 1'b0;
			push_v_q <= 1'b0;
			push_d_q <= '0;
		end else begin
			push_v_q <= 1'b0;
			if (!cmp_en_i) begin
				matched_q <= 1'b0;
			end
			if (smp && last_bit) begin
				if (cmp_en_i && !matched_q) begin
					matched_q <= (pv == (cmp_pattern_i & mask));
				end else if (rx_idx_q == npk_last) begin
					push_v_q <= 1'b1;
					push_d_q <= rx_word_q | (pv <<
						pkt_base(rx_idx_q, bit_len_i));
					rx_word_q <= '0;
					rx_idx_q <= 2'h0;
				end else begin
					rx_word_q <= rx_word_q | (pv <<
						pkt_base(rx_idx_q, bit_len_i));
					rx_idx_q <= rx_idx_q + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			link_chip_select_o <= CS_IDLE;
			link_chip_select_oe_n_o <= CS_IDLE;
			link_serial_clock_o <= 1'b0;
			link_serial_clock_oe_n_o <= 1'b1;
			link_master_out_oe_n_o <= 1'b1;
			link_master_in_oe_n_o <= 1'b1;
			busy_o <= 1'b0;
		end else if (master_en_i) begin
			link_chip_select_o <= ~({cs_sel_i, !cs_sel_i} &
				{2{cs_active}});
			link_chip_select_oe_n_o <= 2'h0;
			link_serial_clock_o <= (state_q == ST_HIGH) ^
				clk_pol_i;
			link_serial_clock_oe_n_o <= 1'b0;
			link_master_out_oe_n_o <= 1'b0;
			link_master_in_oe_n_o <= 1'b1;
			busy_o <= (state_q != ST_IDLE);
		end else begin
			link_chip_select_o <= CS_IDLE;
			link_chip_select_oe_n_o <= CS_IDLE;
			link_serial_clock_o <= clk_pol_i;
			link_serial_clock_oe_n_o <= 1'b1;
			link_master_out_oe_n_o <= 1'b1;
			link_master_in_oe_n_o <= !s_cs_act;
			busy_o <= s_cs_act;
		end
	end

	assign link_master_out_o = out_q;
	assign link_master_in_o = out_q;
	assign cmp_matched_o = matched_q;
endmodule

/* hw/spisc_pkg.sv */
// Constants and types shared by the serial peripheral controller
package spisc_pkg;
	localparam int SYS_CLK_MHZ = 100;
	localparam int MASTER_MAX_MBPS = 65;
	localparam int SLAVE_MAX_MBPS = 45;
	localparam int DATA_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int LEN_W = 5;
	localparam logic [4:0] PACK8_LEN = 5'h07;
	localparam logic [4:0] PACK16_LEN = 5'h0f;
	localparam logic [1:0] PACK8_LAST = 2'h3;
	localparam logic [1:0] PACK16_LAST = 2'h1;
	localparam int SYNC_STAGES = 2;
	// Shortest half period that the master rate allows, rounded up
	localparam int RATE_HALF_CYC =
		(1000 * SYS_CLK_MHZ + 2000 * MASTER_MAX_MBPS - 1) /
		(2000 * MASTER_MAX_MBPS);
	localparam int CS_HIGH_NS = 10;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int HALF_MIN_RAW = (RATE_HALF_CYC > SYNC_STAGES) ?
		RATE_HALF_CYC : SYNC_STAGES;
	localparam int HALF_MIN_INT = (HALF_MIN_RAW > CS_HIGH_CYC) ?
		HALF_MIN_RAW : CS_HIGH_CYC;
	localparam logic [7:0] HALF_MIN_CYC = 8'(HALF_MIN_INT);
	localparam logic [7:0] HCNT_RST = 8'h01;
	localparam int SYNC_SCK = 0;
	localparam int SYNC_CSN = 1;
	localparam int SYNC_MOSI = 2;
	localparam int SYNC_MISO = 3;
	localparam logic [3:0] SYNC_RST = 4'hf;
	localparam logic [1:0] CS_IDLE = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW = 2'b01,
		ST_HIGH = 2'b10,
		ST_GAP = 2'b11
	} spisc_state_type;
endpackage

/* testbench/spisc_link_model.sv */
// Behavioural peripheral on the far side of the serial link
module spisc_link_model (
	input wire logic cs_n_i, // Select, low active
	input wire logic sclk_i, // Link clock
	input wire logic mosi_i, // Data from master
	input wire logic pol_i, // Idle clock level
	input wire logic [31:0] resp_i, // Reply, MSB first
	output logic miso_o, // Data to master
	output logic [31:0] got_o // Bits taken in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] sh;
	initial miso_o = 1'b0;
	always @(negedge cs_n_i) begin
		sh = resp_i;
		miso_o = sh[31];
		got_o = '0;
	end
	// Released line falls to its pull-down
	always @(posedge cs_n_i) miso_o = 1'b0;
	always @(sclk_i) begin
		if (!cs_n_i && sclk_i !== pol_i) got_o = {got_o[30:0], mosi_i};
		else if (!cs_n_i) begin
			sh = sh << 1;
			miso_o = sh[31];
		end
	end
endmodule

/* testbench/spisc_controller_properties.sv */
// Concurrent checks on the controller's ports
module spisc_controller_properties
	import spisc_pkg::*;
(
	input wire logic ref_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic master_en_i, // Role
	input wire logic cs_auto_i, // Select mode
	input wire logic cs_sw_assert_i, // Software select
	input wire logic cs_sel_i, // Select pin
	input wire logic clk_pol_i, // Idle level
	input wire logic tx_valid_i, // Tx write
	input wire logic tx_ready_o, // Tx room
	input wire logic busy_o, // Busy
	input wire logic rx_valid_o, // Rx head
	input wire logic rx_ready_i, // Rx take
	input wire logic [31:0] rx_data_o, // Rx data
	input wire logic [1:0] link_chip_select_o, // Selects
	input wire logic link_serial_clock_o, // Clock pin
	input wire logic link_serial_clock_oe_n_o, // Clock enable
	input wire logic link_master_out_o, // Data out
	input wire logic link_master_out_oe_n_o, // Out enable
	input wire logic link_master_in_oe_n_o // In enable
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_cs_never_both: assert property (link_chip_select_o != 2'h0)
		else $error("both selects low");
	a_cs_pick_one: assert property (master_en_i && $stable(cs_sel_i) &&
		link_chip_select_o != CS_IDLE |-> link_chip_select_o[!cs_sel_i])
		else $error("wrong select pin low");
	a_clk_idle_level: assert property (master_en_i && &link_chip_select_o &&
		$stable(clk_pol_i) && !$past(rst_i) |-> link_serial_clock_o == clk_pol_i)
		else $error("clock not idle while deselected");
	a_master_drives: assert property (master_en_i && !$past(rst_i) |->
		!link_serial_clock_oe_n_o && !link_master_out_oe_n_o &&
		link_master_in_oe_n_o) else $error("pin enables wrong in master");
	a_sw_select: assert property (master_en_i && !cs_auto_i &&
		$stable(cs_auto_i) && $stable(cs_sel_i) && !$past(rst_i) |->
		link_chip_select_o[cs_sel_i] == !$past(cs_sw_assert_i))
		else $error("select not following software");
	a_clk_half_min: assert property (master_en_i && !$past(rst_i) &&
		$changed(link_serial_clock_o) |=> $stable(link_serial_clock_o))
		else $error("clock phase too short");
	a_rx_head_holds: assert property (rx_valid_o && !rx_ready_i |=>
		rx_valid_o && $stable(rx_data_o)) else $error("rx head lost");
	a_out_steady: assert property (master_en_i &&
		$rose(link_serial_clock_o ^ clk_pol_i) |=> $stable(link_master_out_o))
		else $error("data moved after leading edge");
	a_busy_select: assert property (master_en_i && cs_auto_i &&
		$stable(cs_auto_i) && link_chip_select_o != CS_IDLE |-> busy_o)
		else $error("select low while not busy");
	c_tx_full: cover property (tx_valid_i && !tx_ready_o);
	c_sel_one: cover property (!link_chip_select_o[1]);
	c_pol_high: cover property (clk_pol_i && link_chip_select_o != CS_IDLE);
endmodule
bind spisc_controller spisc_controller_properties i_props (.ref_clk_i,
	.rst_i, .master_en_i, .cs_auto_i, .cs_sw_assert_i, .cs_sel_i,
	.clk_pol_i, .tx_valid_i, .tx_ready_o, .busy_o, .rx_valid_o, .rx_ready_i,
	.rx_data_o, .link_chip_select_o, .link_serial_clock_o,
	.link_serial_clock_oe_n_o, .link_master_out_o, .link_master_out_oe_n_o,
	.link_master_in_oe_n_o);

/* testbench/tb.sv */
// Self-checking bench for the serial peripheral controller
module tb
	import spisc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic pol;
		logic sel;
		logic [4:0] len;
		logic [31:0] tx;
		logic [31:0] resp;
	} spisc_row_type;
	spisc_row_type rows [5] = '{
		'{1'b0, 1'b0, 5'h00, 32'h00000001, 32'h80000000},
		'{1'b0, 1'b0, 5'h07, 32'h000000a5, 32'h3c000000},
		'{1'b1, 1'b0, 5'h0f, 32'h0000c3a1, 32'h9e5b0000},
		'{1'b0, 1'b0, 5'h1f, 32'h96e13c5a, 32'h12345678},
		'{1'b0, 1'b1, 5'h04, 32'h00000015, 32'hf0000000}};
	logic ref_clk_i = 0, rst_i = 1, pol = 0, sel = 0, pk = 0, auto_cs = 1;
	logic sw = 0, cmp = 0, txv = 0, rxr = 0;
	logic [4:0] len = 0;
	logic [31:0] txd = 0, pat = 0, resp = 0, d, m;
	logic busy, match, txr, rxv, sclk, sclk_oe_n, mo, mo_oe_n, mi, mi_oe_n;
	logic miso;
	logic [31:0] rxd, got;
	logic [1:0] cs, cs_oe_n;
	wire logic [1:0] cs_w = cs | cs_oe_n;
	wire logic sclk_w = sclk & !sclk_oe_n;
	wire logic mo_w = mo & !mo_oe_n;
	wire logic mi_w = mi_oe_n ? miso : mi;
	int error_cnt = 0, compares = 0, n = 0, k = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	spisc_controller i_dut (.ref_clk_i, .rst_i, .master_en_i(1'b1),
		.bit_len_i(len), .packed_i(pk), .cs_auto_i(auto_cs),
		.cs_sw_assert_i(sw), .cs_sel_i(sel), .clk_pol_i(pol),
		.half_period_i(8'h04), .cmp_en_i(cmp), .cmp_pattern_i(pat),
		.busy_o(busy), .cmp_matched_o(match), .tx_data_i(txd),
		.tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv),
		.rx_ready_i(rxr), .link_chip_select_i(cs_w), .link_chip_select_o(cs),
		.link_chip_select_oe_n_o(cs_oe_n), .link_serial_clock_i(sclk_w),
		.link_serial_clock_o(sclk), .link_serial_clock_oe_n_o(sclk_oe_n),
		.link_master_out_i(mo_w), .link_master_out_o(mo),
		.link_master_out_oe_n_o(mo_oe_n), .link_master_in_i(mi_w),
		.link_master_in_o(mi), .link_master_in_oe_n_o(mi_oe_n));
	spisc_link_model i_link (.cs_n_i(cs_w[0]), .sclk_i(sclk_w),
		.mosi_i(mo_w), .pol_i(pol), .resp_i(resp), .miso_o(miso), .got_o(got));
	task automatic chk(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic push(input logic [31:0] w);
		@(posedge ref_clk_i);
		txv <= 1'b1;
		txd <= w;
		@(posedge ref_clk_i);
		while (txr !== 1'b1) @(posedge ref_clk_i);
		txv <= 1'b0;
	endtask
	// Extra edge first, so the word just taken is not read twice
	task automatic pop(output logic [31:0] w);
		@(posedge ref_clk_i);
		while (rxv !== 1'b1) @(posedge ref_clk_i);
		w = rxd;
		rxr <= 1'b1;
		@(posedge ref_clk_i);
		rxr <= 1'b0;
	endtask
	task automatic idle_wait();
		repeat (4) @(posedge ref_clk_i);
		while (busy !== 1'b0) @(posedge ref_clk_i);
		repeat (4) @(posedge ref_clk_i);
	endtask
	initial begin
		#200us;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		chk("enables in reset", 32'h1f, {cs_oe_n, sclk_oe_n, mo_oe_n, mi_oe_n});
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1 chk("flags after reset", 32'h4, {txr, rxv, busy});
		foreach (rows[i]) begin
			@(posedge ref_clk_i);
			{pol, sel, len} <= {rows[i].pol, rows[i].sel, rows[i].len};
			resp = rows[i].resp;
			m = 32'hffffffff >> (31 - rows[i].len);
			repeat (4) @(posedge ref_clk_i);
			push(rows[i].tx);
			pop(d);
			chk("rx word", rows[i].sel ? 32'h0 : resp >> (31 - len), d);
			if (!rows[i].sel) chk("link out", rows[i].tx & m, got);
		end
		sel <= 1'b0;
		len <= 5'h07;
		pk <= 1'b1;
		resp = 32'ha5000000;
		push(32'h44332211);
		pop(d);
		chk("packed rx", 32'ha5a5a5a5, d);
		chk("last packet out", 32'h44, got);
		pk <= 1'b0;
		cmp <= 1'b1;
		pat <= 32'h000000a5;
		resp = 32'h3c000000;
		push(32'h0);
		idle_wait();
		chk("no match yet", 32'h0, {match, rxv});
		resp = 32'ha5000000;
		push(32'h0);
		idle_wait();
		chk("matched, dropped", 32'h2, {match, rxv});
		resp = 32'h77000000;
		push(32'h0);
		pop(d);
		chk("after match", 32'h77, d);
		cmp <= 1'b0;
		auto_cs <= 1'b0;
		push(32'h5a);
		repeat (60) @(posedge ref_clk_i);
		chk("held by software", 32'h3, {rxv, cs});
		sw <= 1'b1;
		pop(d);
		chk("software rx", 32'h77, d);
		chk("select kept low", 32'h2, cs);
		sw <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		auto_cs <= 1'b1;
		len <= 5'h00;
		txv <= 1'b1;
		repeat (600) begin
			@(posedge ref_clk_i);
			if (txr === 1'b1) n++;
		end
		txv <= 1'b0;
		chk("tx refused when full", 32'h1, {txr, rxv});
		rxr <= 1'b1;
		repeat (2000) begin
			@(posedge ref_clk_i);
			if (rxv === 1'b1 && rxr === 1'b1) k++;
		end
		chk("words drained", n, k);
		stop_test();
	end
endmodule
